// ---- hdl/fsmo_hyst.sv ----
/*
  Threshold comparator with hysteresis for one programmable warning.
  Assumes sample_valid marks a fresh sample of its own quantity.
*/
`timescale 1ns/1ps
module fsmo_hyst
  import fsmo_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                sample_valid,
  input  wire logic                invert,
  input  wire logic [ADC_BITS-1:0] sample,
  input  wire fsmo_limit_t         cfg,
  output logic                     warn_q
);

  wire [10:0] upper    = {1'b0, cfg.limit} + {1'b0, cfg.band};
  wire        under    = cfg.band > cfg.limit;
  wire [9:0]  lower    = cfg.limit - cfg.band;
  wire        above    = {1'b0, sample} > upper;
  wire        below    = !under && (sample < lower);
  wire        disabled = upper > ENABLE_MAX;
  wire        set_hit  = invert ? below : above;
  wire        clr_hit  = invert ? above : below;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || disabled) begin
      warn_q <= 1'b0;
    end else if (sample_valid && set_hit) begin
      warn_q <= 1'b1;
    end else if (sample_valid && clr_hit) begin
      warn_q <= 1'b0;
    end
  end

endmodule : fsmo_hyst

// ---- hdl/fsmo_monitor.sv ----
/*
  Measurement sequencer, warning and error status, capture registers,
  block disable latches and the open-drain interrupt of the monitor.
  Assumes synchronous inputs, a converter that answers with adc_valid,
  and fast fault comparators outside that deliver plain levels.
*/
// Function
// - One converter sweeps nine measured quantities.
// - Sampling runs only with measure enable set.
// - Every quantity sampled each period, 16-bit result.
// - Ten condition bits in warning and error bytes.
// - Live bits follow conditions without latching.
// - Live registers return instantaneous condition values.
// - Rise capture records activations, cleared by read.
// - Live and rise capture read as one snapshot.
// - Fall capture records deactivations, cleared by read.
// - Warnings only set status, no hardware action.
// - Warning sets above upper, clears below lower; undervoltage sets below lower, clears above upper.
// - Warning disabled when limit plus band exceeds 1022.
// - Warning limits reset to 1023, starting disabled.
// - Die heat warning always on, fixed limit.
// - Shutoff warning uses its own temperature limit.
// - Overvoltage warning compares string voltage limit.
// - Buck overcurrent warnings compare averaged current.
// - Errors shown in error byte, disable block.
// - Driver desaturation latches driver off until rearm.
// - Aux buck desaturation latches buck off until rearm.
// - Sense overcurrent flags error, latches driver off.
// - Die shutoff holds everything until below lower.
// - Masked new warning signals host on interrupt.
// - Interrupt level or fixed pulse per occurrence.
`timescale 1ns/1ps
module fsmo_monitor
  import fsmo_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES0
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                measure_enable_bit,
  input  wire logic                driver_enable_bit,
  input  wire logic                aux_buck_enable_bit,
  input  wire logic                irq_pulse_select,
  input  wire fsmo_status_t        rise_irq_mask,
  input  wire fsmo_status_t        fall_irq_mask,
  input  wire logic                limits_write,
  input  wire fsmo_limit_t         string_heat_limit,
  input  wire fsmo_limit_t         string_shutoff_limit,
  input  wire fsmo_limit_t         string_overvolt_limit,
  input  wire fsmo_limit_t         string_undervolt_limit,
  input  wire fsmo_limit_t         main_buck_oc_limit,
  input  wire fsmo_limit_t         aux_buck_oc_limit,
  input  wire logic [ADC_BITS-1:0] adc_data,
  input  wire logic                adc_valid,
  input  wire logic                die_above_heat_limit,
  input  wire logic                die_shutoff_upper,
  input  wire logic                die_shutoff_lower,
  input  wire logic                driver_desat_fault,
  input  wire logic                sense_overcurrent_limit,
  input  wire logic                aux_desat_fault,
  input  wire logic                status_read,
  input  wire logic                fall_read,
  input  wire logic                irq_out_n_i,
  output logic                     adc_start_q,
  output fsmo_chan_t               adc_channel_q,
  output fsmo_results_t            results_q,
  output logic [7:0]               warning_live_reg,
  output logic [7:0]               error_live_reg,
  output fsmo_status_t             live_snapshot_q,
  output fsmo_status_t             rise_capture_reg,
  output fsmo_status_t             fall_capture_reg,
  output logic                     driver_run_q,
  output logic                     aux_run_q,
  output logic                     chip_hold_q,
  output logic                     irq_out_n_o,
  output logic                     irq_out_n_oe_n
);

  typedef enum {ST_IDLE, ST_START, ST_WAIT} fsmo_state_t;

  localparam int TICK_BITS = $clog2(SAMPLE_CYCLES);
  localparam logic [3:0] LAST_CH = 4'(CHANNELS - 1);

  function automatic logic [ACC_BITS-1:0] fsmo_avg(input logic [ACC_BITS-1:0] acc,
                                                    input logic [ADC_BITS-1:0] smp);
    fsmo_avg = acc - (acc >> AVG_SHIFT) + ACC_BITS'(smp);
  endfunction : fsmo_avg

  fsmo_state_t                state_q;
  fsmo_state_t                state_d;
  logic [TICK_BITS-1:0]       tick_q;
  fsmo_limit_t [CFG_COUNT-1:0] cfg_q;
  logic [ACC_BITS-1:0]        main_acc_q;
  logic [ACC_BITS-1:0]        aux_acc_q;
  fsmo_status_t               live_q;
  fsmo_status_t               rise_q;
  fsmo_status_t               fall_q;
  logic                       drv_trip_q;
  logic                       aux_trip_q;
  logic [CFG_COUNT-1:0]       warn_hit;
  logic                       pulse_active;

  // Measurement period and sweep sequencing.
  wire run_ok    = measure_enable_bit && !chip_hold_q;
  wire tick      = run_ok && (tick_q == TICK_BITS'(SAMPLE_CYCLES - 1));
  wire smp_done  = (state_q == ST_WAIT) && adc_valid;
  wire last_ch   = adc_channel_q == fsmo_chan_t'(LAST_CH);
  wire start_d   = (state_q == ST_START) && run_ok;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (tick) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        state_d = run_ok ? ST_WAIT : ST_IDLE;
      end
      ST_WAIT: begin
        if (!run_ok) begin
          state_d = ST_IDLE;
        end else if (adc_valid) begin
          state_d = last_ch ? ST_IDLE : ST_START;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !run_ok || tick) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      adc_start_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      adc_start_q <= start_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      adc_channel_q <= CH_SUPPLY_IN;
    end else if (state_q == ST_IDLE) begin
      adc_channel_q <= CH_SUPPLY_IN;
    end else if (smp_done && !last_ch) begin
      adc_channel_q <= fsmo_chan_t'(adc_channel_q + 1'b1);
    end
  end

  // Results are left aligned in sixteen bits.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      results_q <= '0;
    end else if (smp_done) begin
      results_q[adc_channel_q] <= RESULT_BITS'({adc_data, RESULT_SHIFT'(0)});
    end
  end

  // Running averages of the two buck currents.
  wire main_smp = smp_done && (adc_channel_q == CH_MAIN_BUCK_I);
  wire aux_smp  = smp_done && (adc_channel_q == CH_AUX_BUCK_I);
  wire heat_smp = smp_done && (adc_channel_q == CH_STRING_T);
  wire volt_smp = smp_done && (adc_channel_q == CH_STRING_V);
  wire [ACC_BITS-1:0] main_acc_d = fsmo_avg(main_acc_q, adc_data);
  wire [ACC_BITS-1:0] aux_acc_d  = fsmo_avg(aux_acc_q, adc_data);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      main_acc_q <= '0;
      aux_acc_q  <= '0;
    end else begin
      main_acc_q <= main_smp ? main_acc_d : main_acc_q;
      aux_acc_q  <= aux_smp ? aux_acc_d : aux_acc_q;
    end
  end

  // Warning limits are loaded together and start disabled.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_q <= {CFG_COUNT{LIMIT_RESET, BAND_RESET}};
    end else if (limits_write) begin
      cfg_q[CFG_HEAT]    <= string_heat_limit;
      cfg_q[CFG_SHUTOFF] <= string_shutoff_limit;
      cfg_q[CFG_OVERV]   <= string_overvolt_limit;
      cfg_q[CFG_UNDERV]  <= string_undervolt_limit;
      cfg_q[CFG_MAIN_OC] <= main_buck_oc_limit;
      cfg_q[CFG_AUX_OC]  <= aux_buck_oc_limit;
    end
  end

  fsmo_hyst u_heat (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .sample_valid (heat_smp),
    .invert       (1'b0),
    .sample       (adc_data),
    .cfg          (cfg_q[CFG_HEAT]),
    .warn_q       (warn_hit[CFG_HEAT])
  );

  fsmo_hyst u_shutoff (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .sample_valid (heat_smp),
    .invert       (1'b0),
    .sample       (adc_data),
    .cfg          (cfg_q[CFG_SHUTOFF]),
    .warn_q       (warn_hit[CFG_SHUTOFF])
  );

  fsmo_hyst u_overv (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .sample_valid (volt_smp),
    .invert       (1'b0),
    .sample       (adc_data),
    .cfg          (cfg_q[CFG_OVERV]),
    .warn_q       (warn_hit[CFG_OVERV])
  );

  fsmo_hyst u_underv (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .sample_valid (volt_smp),
    .invert       (1'b1),
    .sample       (adc_data),
    .cfg          (cfg_q[CFG_UNDERV]),
    .warn_q       (warn_hit[CFG_UNDERV])
  );

  fsmo_hyst u_main_oc (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .sample_valid (main_smp),
    .invert       (1'b0),
    .sample       (main_acc_d[ACC_BITS-1:AVG_SHIFT]),
    .cfg          (cfg_q[CFG_MAIN_OC]),
    .warn_q       (warn_hit[CFG_MAIN_OC])
  );

  fsmo_hyst u_aux_oc (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .sample_valid (aux_smp),
    .invert       (1'b0),
    .sample       (aux_acc_d[ACC_BITS-1:AVG_SHIFT]),
    .cfg          (cfg_q[CFG_AUX_OC]),
    .warn_q       (warn_hit[CFG_AUX_OC])
  );

  // Live conditions; warnings feed only status bits.
  fsmo_status_t live_d;
  assign live_d.warn = {1'b0, warn_hit[CFG_AUX_OC], warn_hit[CFG_MAIN_OC], warn_hit[CFG_UNDERV],
                        warn_hit[CFG_OVERV], warn_hit[CFG_SHUTOFF], warn_hit[CFG_HEAT],
                        die_above_heat_limit};
  assign live_d.err  = {5'h00, aux_desat_fault, sense_overcurrent_limit, driver_desat_fault};

  wire [15:0] rise_set = live_d & ~live_q;
  wire [15:0] fall_set = live_q & ~live_d;
  wire [15:0] rise_d   = (status_read ? 16'h0000 : rise_q) | rise_set;
  wire [15:0] fall_d   = (fall_read ? 16'h0000 : fall_q) | fall_set;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      live_q <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      live_q <= live_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign warning_live_reg = live_q.warn;
  assign error_live_reg   = live_q.err;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      live_snapshot_q  <= '0;
      rise_capture_reg <= '0;
      fall_capture_reg <= '0;
    end else begin
      if (status_read) begin
        live_snapshot_q  <= live_q;
        rise_capture_reg <= rise_q;
      end
      if (fall_read) begin
        fall_capture_reg <= fall_q;
      end
    end
  end

  // Block disable latches and thermal hold.
  wire drv_fault  = driver_desat_fault || sense_overcurrent_limit;
  wire drv_trip_d = drv_fault || (drv_trip_q && driver_enable_bit);
  wire aux_trip_d = aux_desat_fault || (aux_trip_q && aux_buck_enable_bit);
  wire hold_d     = die_shutoff_upper || (chip_hold_q && !die_shutoff_lower);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drv_trip_q   <= 1'b0;
      aux_trip_q   <= 1'b0;
      chip_hold_q  <= 1'b0;
      driver_run_q <= 1'b0;
      aux_run_q    <= 1'b0;
    end else begin
      drv_trip_q   <= drv_trip_d;
      aux_trip_q   <= aux_trip_d;
      chip_hold_q  <= hold_d;
      driver_run_q <= driver_enable_bit && !drv_trip_d && !hold_d;
      aux_run_q    <= aux_buck_enable_bit && !aux_trip_d && !hold_d;
    end
  end

  // Interrupt pin; the open drain only ever pulls low.
  wire irq_cond  = |(rise_q & rise_irq_mask) || |(fall_q & fall_irq_mask);
  wire irq_event = |(rise_set & rise_irq_mask) || |(fall_set & fall_irq_mask);
  wire oe_n_d    = irq_pulse_select ? !pulse_active : !irq_cond;

  fsmo_pulse #(
    .CYCLES (PULSE_CYCLES)
  ) u_pulse (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .start    (irq_event),
    .active_q (pulse_active)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_out_n_o    <= 1'b0;
      irq_out_n_oe_n <= 1'b1;
    end else begin
      irq_out_n_o    <= 1'b0;
      irq_out_n_oe_n <= oe_n_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_irq_pulse_start;
    irq_pulse_select && irq_event ##1 irq_pulse_select;
  endsequence

  sequence s_drv_latched;
    drv_trip_q && driver_enable_bit;
  endsequence

  chk_gate_off: assert property (!measure_enable_bit |=> !adc_start_q)
    else $error("converter started while measuring disabled");
  chk_live_follow: assert property (##1 warning_live_reg[W_DIE] == $past(die_above_heat_limit))
    else $error("die heat live bit does not follow its condition");
  chk_rise_clear: assert property ((status_read && rise_set == 16'h0000) |=> rise_q == 16'h0000)
    else $error("rise capture not cleared by read");
  chk_rise_keep: assert property ((status_read && rise_set != 16'h0000) |=>
                                  (rise_q & $past(rise_set)) == $past(rise_set))
    else $error("event lost in clearing read");
  chk_drv_trip: assert property (driver_desat_fault |=> !driver_run_q && error_live_reg[E_DESAT])
    else $error("driver not disabled on desaturation");
  chk_drv_stays: assert property (s_drv_latched |=> !driver_run_q)
    else $error("driver restarted without rearm");
  chk_aux_trip: assert property (aux_desat_fault |=> !aux_run_q && error_live_reg[E_AUX])
    else $error("aux buck not disabled on desaturation");
  chk_oc_flag: assert property (sense_overcurrent_limit |=> error_live_reg[E_STR_OC] && drv_trip_q)
    else $error("overcurrent not flagged or latched");
  chk_rearm_zero: assert property ((!driver_enable_bit && !drv_fault) |=> !drv_trip_q)
    else $error("disable latch not cleared on zero enable");
  chk_hold_stop: assert property (die_shutoff_upper |=> chip_hold_q && !driver_run_q && !aux_run_q)
    else $error("thermal hold did not stop the blocks");
  chk_irq_level: assert property ((!irq_pulse_select && irq_cond) |=> !irq_out_n_oe_n)
    else $error("level interrupt not driven");
  chk_irq_pulse: assert property (s_irq_pulse_start |=> !irq_out_n_oe_n[*8])
    else $error("pulse interrupt too short");

endmodule : fsmo_monitor

// ---- hdl/fsmo_pkg.sv ----
/*
  Shared constants and types of the fault and status monitor.
  Assumes a single 25 MHz system clock and a 10-bit converter outside.
*/
package fsmo_pkg;

  localparam int          ADC_BITS     = 10;
  localparam int          CHANNELS     = 9;
  localparam int          RESULT_BITS  = 16;
  localparam int          RESULT_SHIFT = 6;
  localparam int          AVG_SHIFT    = 2;
  localparam int          ACC_BITS     = ADC_BITS + AVG_SHIFT;
  localparam logic [9:0]  LIMIT_RESET  = 10'h3ff;
  localparam logic [9:0]  BAND_RESET   = 10'h000;
  localparam logic [10:0] ENABLE_MAX   = 11'h3fe;

  localparam int CLK_HZ         = 25_000_000;
  localparam int SAMPLE_MS      = 100;
  localparam int PULSE_US       = 10;
  localparam int SAMPLE_CYCLES0 = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int PULSE_CYCLES   = CLK_HZ / 1_000_000 * PULSE_US;

  localparam int W_DIE     = 0;
  localparam int W_HEAT    = 1;
  localparam int W_SHUTOFF = 2;
  localparam int W_OVERV   = 3;
  localparam int W_UNDERV  = 4;
  localparam int W_MAIN_OC = 5;
  localparam int W_AUX_OC  = 6;
  localparam int E_DESAT   = 0;
  localparam int E_STR_OC  = 1;
  localparam int E_AUX     = 2;

  localparam int CFG_HEAT    = 0;
  localparam int CFG_SHUTOFF = 1;
  localparam int CFG_OVERV   = 2;
  localparam int CFG_UNDERV  = 3;
  localparam int CFG_MAIN_OC = 4;
  localparam int CFG_AUX_OC  = 5;
  localparam int CFG_COUNT   = 6;

  typedef enum logic [3:0] {
    CH_SUPPLY_IN, CH_SUPPLY_CORE, CH_SUPPLY_AUX, CH_STRING_V, CH_STRING_I,
    CH_INPUT_I, CH_MAIN_BUCK_I, CH_AUX_BUCK_I, CH_STRING_T
  } fsmo_chan_t;

  typedef struct packed {
    logic [ADC_BITS-1:0] limit;
    logic [ADC_BITS-1:0] band;
  } fsmo_limit_t;

  typedef struct packed {
    logic [7:0] err;
    logic [7:0] warn;
  } fsmo_status_t;

  typedef logic [CHANNELS-1:0][RESULT_BITS-1:0] fsmo_results_t;

endpackage : fsmo_pkg

// ---- hdl/fsmo_pulse.sv ----
/*
  Retriggerable pulse stretcher for the pulsed interrupt mode.
  Assumes start is a one-cycle event in the system clock domain.
*/
`timescale 1ns/1ps
module fsmo_pulse
  import fsmo_pkg::*;
#(
  parameter int CYCLES = PULSE_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      active_q
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q    <= '0;
      active_q <= 1'b0;
    end else if (start) begin
      cnt_q    <= CW'(CYCLES - 1);
      active_q <= 1'b1;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end else begin
      active_q <= 1'b0;
    end
  end

endmodule : fsmo_pulse

// ---- tb/fsmo_adc_model.sv ----
/*
  Converter model: answers each start with one sample of the chosen channel.
  Assumes start is a one-cycle pulse and the monitor waits for adc_valid.
*/
`timescale 1ns/1ps
module fsmo_adc_model
  import fsmo_pkg::*;
(
  input  wire logic                              sys_clk,
  input  wire logic                              rst_n,
  input  wire logic                              start,
  input  wire fsmo_chan_t                        channel,
  input  wire logic [CHANNELS-1:0][ADC_BITS-1:0] values,
  input  wire logic [3:0]                        latency,
  output logic      [ADC_BITS-1:0]               adc_data,
  output logic                                   adc_valid
);
  logic [3:0] wait_q;
  fsmo_chan_t ch_q;
  logic       busy_q;
  // Outside the valid cycle the data toggles, so stale samples never look valid.
  always_ff @(posedge sys_clk) begin
    adc_valid <= 1'b0;
    adc_data  <= ~adc_data;
    if (!rst_n) begin
      busy_q   <= 1'b0;
      adc_data <= '0;
    end else if (start) begin
      busy_q <= 1'b1;
      wait_q <= latency;
      ch_q   <= channel;
    end else if (busy_q && wait_q == 4'h0) begin
      busy_q    <= 1'b0;
      adc_valid <= 1'b1;
      adc_data  <= values[ch_q];
    end else if (busy_q) begin
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule : fsmo_adc_model

// ---- tb/fsmo_monitor_tb.sv ----
/*
  Self-checking bench of the fault and status monitor with a converter model.
  Assumes a shortened measurement period and a pulled-up interrupt line.
*/
`timescale 1ns/1ps
module fsmo_monitor_tb
  import fsmo_pkg::*;
();
  logic                              sys_clk, rst_n, meas, drv_en, aux_en, psel, lim_wr;
  logic                              status_read, fall_read, die_heat, shut_up, shut_lo;
  logic                              desat, sense_oc, aux_desat, adc_start, adc_valid;
  logic                              drv_run, aux_run, hold, irq_o, irq_oe_n, irq_pin;
  logic [ADC_BITS-1:0]               adc_data;
  logic [CHANNELS-1:0][ADC_BITS-1:0] vals;
  logic [3:0]                        lat;
  logic [7:0]                        wlive, elive;
  logic [15:0]                       lfsr;
  fsmo_status_t                      rmask, fmask, snap, rcap, fcap;
  fsmo_limit_t                       lim [CFG_COUNT];
  fsmo_chan_t                        chan;
  fsmo_results_t                     res;
  int                                errors, comparisons, cycles;
  int                                tv [6] = '{520, 500, 480, 280, 305, 320};
  logic                              tov [6] = '{1, 1, 0, 0, 0, 0};
  logic                              tuv [6] = '{0, 0, 0, 1, 1, 0};

  // The open-drain line has a pull-up outside.
  assign irq_pin = irq_oe_n ? 1'b1 : irq_o;

  fsmo_monitor #(.SAMPLE_CYCLES(50)) fsmo_monitor_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .measure_enable_bit(meas), .driver_enable_bit(drv_en),
    .aux_buck_enable_bit(aux_en), .irq_pulse_select(psel), .rise_irq_mask(rmask),
    .fall_irq_mask(fmask), .limits_write(lim_wr), .string_heat_limit(lim[CFG_HEAT]),
    .string_shutoff_limit(lim[CFG_SHUTOFF]), .string_overvolt_limit(lim[CFG_OVERV]),
    .string_undervolt_limit(lim[CFG_UNDERV]), .main_buck_oc_limit(lim[CFG_MAIN_OC]),
    .aux_buck_oc_limit(lim[CFG_AUX_OC]), .adc_data(adc_data), .adc_valid(adc_valid),
    .die_above_heat_limit(die_heat), .die_shutoff_upper(shut_up), .die_shutoff_lower(shut_lo),
    .driver_desat_fault(desat), .sense_overcurrent_limit(sense_oc), .aux_desat_fault(aux_desat),
    .status_read(status_read), .fall_read(fall_read), .irq_out_n_i(irq_pin),
    .adc_start_q(adc_start), .adc_channel_q(chan), .results_q(res), .warning_live_reg(wlive),
    .error_live_reg(elive), .live_snapshot_q(snap), .rise_capture_reg(rcap),
    .fall_capture_reg(fcap), .driver_run_q(drv_run), .aux_run_q(aux_run), .chip_hold_q(hold),
    .irq_out_n_o(irq_o), .irq_out_n_oe_n(irq_oe_n));

  fsmo_adc_model fsmo_adc_model_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .start(adc_start), .channel(chan), .values(vals),
    .latency(lat), .adc_data(adc_data), .adc_valid(adc_valid));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : next_rand

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  task automatic strobe(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : strobe

  // Draws fresh samples, lets two full sweeps pass and checks every result.
  task automatic sweep(input logic [9:0] v3);
    int i;
    for (int c = 0; c < CHANNELS; c++) begin
      lfsr    = next_rand(lfsr);
      vals[c] = lfsr[9:0];
    end
    vals[CH_STRING_V] = v3;
    lat = lfsr[13:10];
    for (int n = 0; n < 2; n++) begin
      i = 0;
      while (!(adc_valid === 1'b1 && chan === CH_STRING_T) && i < 3000) begin
        tick(1);
        i++;
      end
      tick(1);
    end
    tick(2);
    for (int c = 0; c < CHANNELS; c++) chk_word(res[c], {vals[c], 6'h00});
  endtask : sweep

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    {rst_n, meas, psel, lim_wr, status_read, fall_read, die_heat, shut_up, shut_lo} = '0;
    {desat, sense_oc, aux_desat, rmask, fmask, vals} = '0;
    {drv_en, aux_en} = 2'b11;
    lat = 4'h2;
    lfsr = 16'd39993;
    for (int k = 0; k < CFG_COUNT; k++) lim[k] = '{limit: LIMIT_RESET, band: BAND_RESET};
    tick(2);
    chk_bit(irq_oe_n, 1'b1);
    chk_word({elive, wlive}, 16'h0000);
    rst_n = 1'b1;
    tick(2);
    done("reset");
    meas = 1'b1;
    sweep(10'h3ff);
    chk_word(wlive, 8'h00);
    lim[CFG_OVERV] = '{limit: 10'd1013, band: 10'd10};
    strobe(lim_wr);
    sweep(10'h3ff);
    chk_word(wlive, 8'h00);
    lim[CFG_OVERV] = '{limit: 10'd500, band: 10'd10};
    lim[CFG_UNDERV] = '{limit: 10'd300, band: 10'd10};
    strobe(lim_wr);
    for (int s = 0; s < 6; s++) begin
      sweep(tv[s][9:0]);
      chk_bit(wlive[W_OVERV], tov[s]);
      chk_bit(wlive[W_UNDERV], tuv[s]);
      chk_word(wlive & 8'he7, 8'h00);
    end
    lim[CFG_HEAT] = '{limit: 10'd500, band: 10'd0};
    lim[CFG_SHUTOFF] = '{limit: 10'd700, band: 10'd0};
    strobe(lim_wr);
    sweep(10'd400);
    chk_bit(wlive[W_HEAT], vals[CH_STRING_T] > 10'd500);
    chk_bit(wlive[W_SHUTOFF], vals[CH_STRING_T] > 10'd700);
    lim[CFG_HEAT] = lim[CFG_AUX_OC];
    lim[CFG_SHUTOFF] = lim[CFG_AUX_OC];
    strobe(lim_wr);
    done("thresholds");
    meas = 1'b0;
    vals = ~vals;
    tick(400);
    chk_word(res[CH_SUPPLY_IN], {~vals[CH_SUPPLY_IN], 6'h00});
    done("enable");
    die_heat = 1'b1;
    tick(2);
    chk_bit(wlive[W_DIE], 1'b1);
    strobe(status_read);
    chk_word(snap, 16'h0001);
    chk_bit(rcap.warn[W_DIE], 1'b1);
    die_heat = 1'b0;
    tick(2);
    chk_bit(wlive[W_DIE], 1'b0);
    strobe(status_read);
    strobe(fall_read);
    rmask = 16'h0700;
    for (int f = 0; f < 3; f++) begin
      {aux_desat, sense_oc, desat} = 3'b001 << f;
      tick(1);
      chk_bit(elive[f], 1'b1);
      {aux_desat, sense_oc, desat} = 3'b000;
      tick(1);
      chk_bit(elive[f], 1'b0);
      chk_bit(f == E_AUX ? aux_run : drv_run, 1'b0);
      tick(2);
      chk_bit(irq_pin, 1'b0);
      strobe(status_read);
      chk_bit(rcap.err[f], 1'b1);
      tick(2);
      chk_bit(irq_pin, 1'b1);
      strobe(status_read);
      chk_word(rcap, 16'h0000);
      strobe(fall_read);
      chk_bit(fcap.err[f], 1'b1);
      {aux_en, drv_en} = 2'b00;
      tick(2);
      {aux_en, drv_en} = 2'b11;
      tick(2);
      chk_bit(f == E_AUX ? aux_run : drv_run, 1'b1);
    end
    done("faults");
    {status_read, desat} = 2'b11;
    tick(1);
    chk_bit(rcap.err[E_DESAT], 1'b0);
    {status_read, desat} = 2'b00;
    tick(2);
    strobe(status_read);
    chk_bit(rcap.err[E_DESAT], 1'b1);
    drv_en = 1'b0;
    tick(2);
    drv_en = 1'b1;
    strobe(status_read);
    strobe(fall_read);
    done("read race");
    shut_up = 1'b1;
    tick(2);
    chk_word({hold, drv_run, aux_run}, 3'b100);
    shut_up = 1'b0;
    tick(3);
    chk_bit(hold, 1'b1);
    shut_lo = 1'b1;
    tick(2);
    chk_bit(hold, 1'b0);
    shut_lo = 1'b0;
    done("shutoff");
    {rmask, psel} = {16'h0001, 1'b1};
    die_heat = 1'b1;
    tick(1);
    die_heat = 1'b0;
    tick(100);
    chk_bit(irq_pin, 1'b0);
    tick(200);
    chk_bit(irq_pin, 1'b1);
    {rmask, fmask, psel} = {16'h0000, 16'h0001, 1'b0};
    tick(2);
    chk_bit(irq_pin, 1'b0);
    strobe(fall_read);
    tick(2);
    chk_bit(irq_pin, 1'b1);
    done("pulse");
    report_and_stop();
  end
endmodule : fsmo_monitor_tb
